// ### dgc_cfg.sv
// Configuration registers and field decode of the dynamic gain controller.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module dgc_cfg #(
	parameter int W = 16
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [7:0]   regAddr,
	input  wire logic [15:0]  regWdata,
	input  wire logic         regWr,
	input  wire logic         regRd,
	output logic      [15:0]  regRdata,
	input  wire logic         sampleValid,
	input  wire logic [W-1:0] sampleIn,
	output logic      [W-1:0] lookaheadSample,
	output logic      [11:0]  kneeLevelCdb,
	output logic      [4:0]   firstSlopeShift,
	output logic      [4:0]   secondSlopeShift,
	output logic      [5:0]   crestThresholdDb,
	output logic      [31:0]  decayCycles,
	output logic signed [7:0] initialGainDb,
	output logic              reservedCode
);
	// Stored register contents.
	logic [15:0] knee_qr;
	logic [15:0] slope2_gain;
	// Fields split out of the stored words.
	logic [4:0]  kneeAmplitude;
	logic [2:0]  firstSlope;
	logic        anticlipLookaheadSel;
	logic [1:0]  fastReleaseCrestThreshold;
	logic [1:0]  fastReleaseDecayRate;
	logic [2:0]  secondSlope;
	logic [4:0]  initialGain;
	// Delay line tap and its output.
	logic [3:0]  tapSel;
	logic [W-1:0] delayed;

	assign kneeAmplitude = knee_qr[dgc_cfg_pkg::KNEE_MSB:dgc_cfg_pkg::KNEE_LSB];
	assign firstSlope =
		knee_qr[dgc_cfg_pkg::SLOPE1_MSB:dgc_cfg_pkg::SLOPE1_LSB];
	assign anticlipLookaheadSel = knee_qr[dgc_cfg_pkg::LOOK_BIT];
	assign fastReleaseCrestThreshold =
		knee_qr[dgc_cfg_pkg::CREST_MSB:dgc_cfg_pkg::CREST_LSB];
	assign fastReleaseDecayRate =
		knee_qr[dgc_cfg_pkg::RATE_MSB:dgc_cfg_pkg::RATE_LSB];
	assign secondSlope =
		slope2_gain[dgc_cfg_pkg::SLOPE2_MSB:dgc_cfg_pkg::SLOPE2_LSB];
	assign initialGain =
		slope2_gain[dgc_cfg_pkg::GAIN_MSB:dgc_cfg_pkg::GAIN_LSB];

	// Register writes; unused bits are masked so they read as zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			knee_qr     <= dgc_cfg_pkg::RST_KNEE_QR;
			slope2_gain <= dgc_cfg_pkg::RST_SLOPE2_GAIN;
		end else if (regWr) begin
			if (regAddr == dgc_cfg_pkg::ADDR_KNEE_QR) begin
				knee_qr <= regWdata & dgc_cfg_pkg::MASK_KNEE_QR;
			end
			if (regAddr == dgc_cfg_pkg::ADDR_SLOPE2_GAIN) begin
				slope2_gain <= regWdata & dgc_cfg_pkg::MASK_SLOPE2_GAIN;
			end
		end
	end

	// Read data stands in the cycle after the strobe only; else zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			regRdata <= 16'h0000;
		end else if (regRd && regAddr == dgc_cfg_pkg::ADDR_KNEE_QR) begin
			regRdata <= knee_qr;
		end else if (regRd && regAddr == dgc_cfg_pkg::ADDR_SLOPE2_GAIN) begin
			regRdata <= slope2_gain;
		end else begin
			regRdata <= 16'h0000;
		end
	end

	// Knee level as attenuation in hundredths of a dB.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			kneeLevelCdb <= 12'h000;
		end else begin
			// Product stays below 4096 for every legal code.
			kneeLevelCdb <= 12'(kneeAmplitude
				* dgc_cfg_pkg::KNEE_STEP_CDB);
		end
	end

	// Slopes as right-shift counts; all-ones shift means a flat slope.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			firstSlopeShift <= 5'h00;
		end else if (firstSlope == dgc_cfg_pkg::SLOPE1_MAX) begin
			firstSlopeShift <= dgc_cfg_pkg::SHIFT_ZERO;
		end else begin
			firstSlopeShift <= {2'h0, firstSlope};
		end
	end

	// Second slope decode, zero at its top legal code.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			secondSlopeShift <= 5'h00;
		end else if (secondSlope == dgc_cfg_pkg::SLOPE2_MAX) begin
			secondSlopeShift <= dgc_cfg_pkg::SHIFT_ZERO;
		end else begin
			secondSlopeShift <= {2'h0, secondSlope};
		end
	end

	// Crest factor threshold selection.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			crestThresholdDb <= dgc_cfg_pkg::CREST_DB0;
		end else begin
			case (fastReleaseCrestThreshold)
				2'h0: crestThresholdDb <= dgc_cfg_pkg::CREST_DB0;
				2'h1: crestThresholdDb <= dgc_cfg_pkg::CREST_DB1;
				2'h2: crestThresholdDb <= dgc_cfg_pkg::CREST_DB2;
				default: crestThresholdDb <= dgc_cfg_pkg::CREST_DB3;
			endcase
		end
	end

	// Decay time per 6 dB in clock cycles; reserved code keeps the fastest.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			decayCycles <= 32'(dgc_cfg_pkg::RATE_CYC0);
		end else begin
			case (fastReleaseDecayRate)
				2'h1: decayCycles <= 32'(dgc_cfg_pkg::RATE_CYC1);
				2'h2: decayCycles <= 32'(dgc_cfg_pkg::RATE_CYC2);
				default: decayCycles <= 32'(dgc_cfg_pkg::RATE_CYC0);
			endcase
		end
	end

	// Initial gain in dB for the gain engine's start.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			initialGainDb <= 8'sh00;
		end else begin
			initialGainDb <= 8'(dgc_cfg_pkg::GAIN_BASE_DB
				+ int'(initialGain) * dgc_cfg_pkg::GAIN_STEP_DB);
		end
	end

	// Flags any reserved code that software wrote anyway.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reservedCode <= 1'b0;
		end else begin
			reservedCode <= (kneeAmplitude > dgc_cfg_pkg::KNEE_MAX)
				|| (firstSlope > dgc_cfg_pkg::SLOPE1_MAX)
				|| (fastReleaseDecayRate > dgc_cfg_pkg::RATE_MAX)
				|| (secondSlope > dgc_cfg_pkg::SLOPE2_MAX)
				|| (initialGain > dgc_cfg_pkg::GAIN_MAX);
		end
	end

	// Tap depth follows the lookahead select.
	assign tapSel = anticlipLookaheadSel ? 4'(dgc_cfg_pkg::LOOK_LONG)
		: 4'(dgc_cfg_pkg::LOOK_SHORT);

	// Feed-forward delay line for anti-clip.
	dgc_delay_line #(
		.W     (W),
		.DEPTH (dgc_cfg_pkg::LOOK_LONG)
	) u_delay (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.sampleValid (sampleValid),
		.sampleIn    (sampleIn),
		.tapSel      (tapSel),
		.sampleOut   (delayed)
	);

	// Register the delayed sample onto the output.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lookaheadSample <= '0;
		end else begin
			lookaheadSample <= delayed;
		end
	end

	// Assertions.
	a_read_data_zero: assert property (@(posedge ref_clk) disable iff (rst)
		!$past(regRd) |-> regRdata == 16'h0000)
		else $error("read data not zero without read");
	a_read_back_first: assert property (@(posedge ref_clk) disable iff (rst)
		regRd && regAddr == dgc_cfg_pkg::ADDR_KNEE_QR
		|=> regRdata == $past(knee_qr))
		else $error("first register read mismatch");
	a_knee_scale: assert property (@(posedge ref_clk) disable iff (rst)
		$stable(kneeAmplitude) |=> kneeLevelCdb
		== 12'($past(kneeAmplitude) * dgc_cfg_pkg::KNEE_STEP_CDB))
		else $error("knee level wrong");
	a_slope_zero: assert property (@(posedge ref_clk) disable iff (rst)
		firstSlope == 3'h5 |=> firstSlopeShift == 5'h1F)
		else $error("first slope zero not decoded");
	a_lookahead_tap: assert property (@(posedge ref_clk) disable iff (rst)
		tapSel == (anticlipLookaheadSel ? 4'h9 : 4'h5))
		else $error("lookahead tap wrong");
	a_crest_map: assert property (@(posedge ref_clk) disable iff (rst)
		fastReleaseCrestThreshold == 2'h1 |=> crestThresholdDb == 6'h12)
		else $error("crest threshold wrong");
	a_decay_map: assert property (@(posedge ref_clk) disable iff (rst)
		fastReleaseDecayRate == 2'h2 |=> decayCycles == 32'd145000)
		else $error("decay cycles wrong");
	a_slope2_zero: assert property (@(posedge ref_clk) disable iff (rst)
		secondSlope == 3'h4 |=> secondSlopeShift == 5'h1F)
		else $error("second slope zero not decoded");
	a_gain_top: assert property (@(posedge ref_clk) disable iff (rst)
		initialGain == 5'h12 |=> initialGainDb == 8'sd36)
		else $error("initial gain top wrong");
	a_reserved_flag: assert property (@(posedge ref_clk) disable iff (rst)
		kneeAmplitude == 5'h1F |=> reservedCode)
		else $error("reserved code not flagged");

	c_write_first: cover property (@(posedge ref_clk)
		regWr && regAddr == dgc_cfg_pkg::ADDR_KNEE_QR);
	c_read_second: cover property (@(posedge ref_clk)
		regRd && regAddr == dgc_cfg_pkg::ADDR_SLOPE2_GAIN);
	c_short_look: cover property (@(posedge ref_clk)
		!anticlipLookaheadSel && sampleValid);
endmodule

// ### dgc_cfg_pkg.sv
// Package with register map, field layout and decode constants.
package dgc_cfg_pkg;
	// Register indices as printed; byte-free plain port uses them directly.
	localparam logic [7:0]  ADDR_KNEE_QR     = 8'h7D;
	localparam logic [7:0]  ADDR_SLOPE2_GAIN = 8'h7E;
	// Field positions of the first register.
	localparam int          KNEE_MSB   = 15;
	localparam int          KNEE_LSB   = 11;
	localparam int          SLOPE1_MSB = 10;
	localparam int          SLOPE1_LSB = 8;
	localparam int          LOOK_BIT   = 7;
	localparam int          CREST_MSB  = 3;
	localparam int          CREST_LSB  = 2;
	localparam int          RATE_MSB   = 1;
	localparam int          RATE_LSB   = 0;
	// Field positions of the second register.
	localparam int          SLOPE2_MSB = 15;
	localparam int          SLOPE2_LSB = 13;
	localparam int          GAIN_MSB   = 12;
	localparam int          GAIN_LSB   = 8;
	// Reset values and writable bit masks.
	localparam logic [15:0] RST_KNEE_QR     = 16'h0080;
	localparam logic [15:0] RST_SLOPE2_GAIN = 16'h0600;
	localparam logic [15:0] MASK_KNEE_QR     = 16'hFF8F;
	localparam logic [15:0] MASK_SLOPE2_GAIN = 16'hFF00;
	// Lookahead depths in sample periods.
	localparam int          LOOK_SHORT = 5;
	localparam int          LOOK_LONG  = 9;
	// Largest legal codes of each field that has reserved codes.
	localparam logic [4:0]  KNEE_MAX   = 5'h1E;
	localparam logic [2:0]  SLOPE1_MAX = 3'h5;
	localparam logic [2:0]  SLOPE2_MAX = 3'h4;
	localparam logic [1:0]  RATE_MAX   = 2'h2;
	localparam logic [4:0]  GAIN_MAX   = 5'h12;
	// Knee step in hundredths of a dB, gain step and base in dB.
	localparam int          KNEE_STEP_CDB = 75;
	localparam int          GAIN_STEP_DB  = 3;
	localparam int          GAIN_BASE_DB  = -18;
	// Crest thresholds in dB, decay times in microseconds per 6 dB.
	localparam logic [5:0]  CREST_DB0 = 6'h0C;
	localparam logic [5:0]  CREST_DB1 = 6'h12;
	localparam logic [5:0]  CREST_DB2 = 6'h18;
	localparam logic [5:0]  CREST_DB3 = 6'h1E;
	localparam real         RATE_US0  = 725.0;
	localparam real         RATE_US1  = 1450.0;
	localparam real         RATE_US2  = 5800.0;
	localparam real         CLK_NS    = 40.0;
	// Decay times in clock cycles, rounded down.
	localparam int RATE_CYC0 = int'($floor(RATE_US0 * 1000.0 / CLK_NS));
	localparam int RATE_CYC1 = int'($floor(RATE_US1 * 1000.0 / CLK_NS));
	localparam int RATE_CYC2 = int'($floor(RATE_US2 * 1000.0 / CLK_NS));
	// Slope shift code meaning zero gain slope.
	localparam logic [4:0]  SHIFT_ZERO = 5'h1F;
endpackage

// ### dgc_delay_line.sv
// Sample delay line with selectable tap depth.
`timescale 1ns/100ps
module dgc_delay_line #(
	parameter int W     = 16,
	parameter int DEPTH = 9
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         sampleValid,
	input  wire logic [W-1:0] sampleIn,
	input  wire logic [3:0]   tapSel,
	output logic      [W-1:0] sampleOut
);
	// Shift storage, one word per sample period.
	logic [W-1:0] stage [DEPTH];

	// Shift by one on each sample strobe.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= '0;
			end
		end else if (sampleValid) begin
			stage[0] <= sampleIn;
			for (int i = 1; i < DEPTH; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	// Tap n holds the sample taken n strobes ago.
	always_comb begin
		sampleOut = stage[tapSel - 4'h1];
	end
endmodule

// ### tb.sv
// Self-checking testbench for the gain controller configuration block.
`timescale 1ns/100ps
module tb;
	logic               ref_clk;          // 25 MHz system clock.
	logic               rst;              // Synchronous reset, high.
	logic        [7:0]  regAddr;          // Register index.
	logic        [15:0] regWdata;         // Write data.
	logic               regWr;            // Write strobe.
	logic               regRd;            // Read strobe.
	logic        [15:0] regRdata;         // Read data.
	logic               sampleValid;      // Audio sample strobe.
	logic        [15:0] sampleIn;         // Audio sample.
	logic        [15:0] lookaheadSample;  // Delayed sample.
	logic        [11:0] kneeLevelCdb;     // Knee attenuation.
	logic        [4:0]  firstSlopeShift;  // First slope shift.
	logic        [4:0]  secondSlopeShift; // Second slope shift.
	logic        [5:0]  crestThresholdDb; // Crest threshold.
	logic        [31:0] decayCycles;      // Decay time in cycles.
	logic signed [7:0]  initialGainDb;    // Start-up gain.
	logic               reservedCode;     // Reserved code flag.
	int                 badCount;         // Mismatches seen.
	int                 checks;           // Comparisons made.
	logic        [15:0] rv;               // Scratch read value.

	dgc_cfg #(.W(16)) uut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .sampleValid(sampleValid),
		.sampleIn(sampleIn), .lookaheadSample(lookaheadSample),
		.kneeLevelCdb(kneeLevelCdb), .firstSlopeShift(firstSlopeShift),
		.secondSlopeShift(secondSlopeShift),
		.crestThresholdDb(crestThresholdDb), .decayCycles(decayCycles),
		.initialGainDb(initialGainDb), .reservedCode(reservedCode));

	// Clock with a 40 ns period.
	always #20 ref_clk = ~ref_clk;

	// Counts a comparison and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		checks++;
		if (got !== ex) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// One write cycle, then waits until the decode outputs have settled.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	// One read cycle; the data are taken in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask

	// Reset values of both registers and of the crest, decay and gain settings.
	task automatic reset_values;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("crest", 32'h0C, {26'h0, crestThresholdDb});
		chk("decay", 32'h46CD, decayCycles);
		chk("gain", 32'h00, {24'h0, initialGainDb});
		rd(dgc_cfg_pkg::ADDR_KNEE_QR, rv);
		chk("reg1", 32'h0080, {16'h0, rv});
		rd(dgc_cfg_pkg::ADDR_SLOPE2_GAIN, rv);
		chk("reg2", 32'h0600, {16'h0, rv});
	endtask

	// Every legal slope, crest and decay code of the first register; knee codes in steps of 6, lookahead off.
	task automatic first_reg;
		logic [4:0] s1[6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1F};
		logic [31:0] dc[3] = '{32'h46CD, 32'h8D9A, 32'h23668};
		logic [5:0] cr[4] = '{6'h0C, 6'h12, 6'h18, 6'h1E};
		for (int i = 0; i < 6; i++) begin
			wr(8'h7D, {5'(i * 6), 3'(i), 4'h0, 2'(i % 4), 2'(i % 3)});
			chk("knee", 32'(i * 450), {20'h0, kneeLevelCdb});
			chk("slope1", {27'h0, s1[i]}, {27'h0, firstSlopeShift});
			chk("crest", {26'h0, cr[i % 4]}, {26'h0, crestThresholdDb});
			chk("decay", dc[i % 3], decayCycles);
			chk("flag", 32'h0, {31'h0, reservedCode});
		end
	endtask

	// Second slope codes and start-up gain codes up to the top one.
	task automatic second_reg;
		logic [4:0] s2[5] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1F};
		logic [4:0] gc[5] = '{5'h00, 5'h06, 5'h0A, 5'h11, 5'h12};
		for (int i = 0; i < 5; i++) begin
			wr(8'h7E, {3'(i), gc[i], 8'h00});
			chk("slope2", {27'h0, s2[i]}, {27'h0, secondSlopeShift});
			chk("gain", {24'h0, 8'(-18 + 3 * int'(gc[i]))},
				{24'h0, initialGainDb});
		end
	endtask

	// Reserved codes raise the flag; a legal rewrite clears it.
	task automatic reserved_codes;
		logic [7:0] ra[5] = '{8'h7D, 8'h7D, 8'h7D, 8'h7E, 8'h7E};
		logic [15:0] rw[5] = '{16'hF880, 16'h0680, 16'h0083, 16'hA600,
			16'h1300};
		for (int i = 0; i < 5; i++) begin
			wr(ra[i], rw[i]);
			chk("flag", 32'h1, {31'h0, reservedCode});
			wr(ra[i], ra[i][0] ? 16'h0080 : 16'h0600);
			chk("flag", 32'h0, {31'h0, reservedCode});
		end
	endtask

	// Unused bits read zero and an unmapped index neither stores nor reads.
	task automatic mask_unmapped;
		wr(8'h7D, 16'hFFFF);
		rd(8'h7D, rv);
		chk("reg1", 32'hFF8F, {16'h0, rv});
		wr(8'h7E, 16'hFFFF);
		rd(8'h7E, rv);
		chk("reg2", 32'hFF00, {16'h0, rv});
		wr(8'h7F, 16'h1234);
		rd(8'h7F, rv);
		chk("unmapped", 32'h0, {16'h0, rv});
	endtask

	// Back-to-back strobes; the first sample emerges after n more strobes.
	task automatic lookahead(input logic sel, input int n);
		wr(8'h7D, {8'h00, sel, 7'h00});
		for (int i = 0; i <= n; i++) begin
			@(posedge ref_clk);
			sampleValid <= 1'b1;
			sampleIn <= 16'h1000 + 16'(i);
		end
		// The last strobe is taken here; the first sample shows now.
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		#1;
		chk("lookahead", 32'h1000, {16'h0, lookaheadSample});
		// One clock later the second sample follows, pinning the depth.
		@(posedge ref_clk);
		#1;
		chk("lookahead", 32'h1001, {16'h0, lookaheadSample});
	endtask

	// Prints the verdict and ends the run.
	task automatic stop_test;
		if (badCount == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence: reset for ten cycles, then each scenario in turn.
	initial begin
		{ref_clk, regWr, regRd, sampleValid} = 4'h0;
		{regAddr, regWdata, sampleIn} = 40'h0;
		rst = 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		reset_values();
		first_reg();
		second_reg();
		reserved_codes();
		mask_unmapped();
		lookahead(1'b1, 9);
		lookahead(1'b0, 5);
		stop_test();
	end

	// Watchdog far beyond the roughly 120 cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge ref_clk);
		badCount++;
		stop_test();
	end
endmodule
